// File: logic/fdlr_core.sv
// Fragment dither, bitwise combine, per-sample handling and resolve
`timescale 1ns/100ps
`default_nettype none
`include "fdlr_cfg.svh"
module fdlr_core
	import fdlr_pkg::*;
(
	input  wire logic                      clk_i,
	input  wire logic                      rst_n_i,
	input  wire logic [`FDLR_AW-1:0]       addr_i,
	input  wire logic [7:0]                wdata_i,
	input  wire logic                      wr_i,
	input  wire logic                      rd_i,
	output logic [7:0]                     rdata_o,
	input  wire fdlr_frag_type             frag_i,
	output logic                           valid_o,
	output logic [1:0][3:0]                smp_we_o,
	output fdlr_color_type [1:0][3:0]      smp_color_o,
	output logic                           stencil_all_o,
	output logic [1:0]                     buf_we_o,
	output fdlr_color_type [1:0]           buf_color_o
);
	fdlr_state_type st;
	fdlr_state_type next_st;

	// Ordered 4x4 threshold; depends on window position only, so repeatable
	function automatic logic [3:0] fdlr_thresh(input logic [1:0] x, input logic [1:0] y);
		logic [15:0][3:0] m;
		m = {4'h5, 4'hd, 4'h7, 4'hf,
			4'h9, 4'h1, 4'hb, 4'h3,
			4'h6, 4'he, 4'h4, 4'hc,
			4'ha, 4'h2, 4'h8, 4'h0};
		fdlr_thresh = m[{y, x}];
	endfunction

	// Reduce one component to the stored width
	function automatic logic [7:0] fdlr_reduce(input logic [11:0] c, input logic dith,
		input logic [3:0] th);
		logic [7:0] lo;
		logic [3:0] fr;
		lo = c[11:`FDLR_FRAC];
		fr = c[`FDLR_FRAC-1:0];
		fdlr_reduce = lo;
		// Upper candidate only when input is off grid and lo is not the top code
		if (dith && fr > th && lo != 8'hff) begin
			fdlr_reduce = lo + 8'h01;
		end
		// lo == ff keeps the only existing candidate
	endfunction

	// One bitwise function over a whole component
	function automatic logic [7:0] fdlr_bitop(input fdlr_fn_type f, input logic [7:0] s,
		input logic [7:0] d);
		case (f)
			fn_zero:            fdlr_bitop = 8'h00;
			fn_and:             fdlr_bitop = s & d;
			fn_src_and_not_dst: fdlr_bitop = s & ~d;
			fn_copy:            fdlr_bitop = s;
			fn_not_src_and_dst: fdlr_bitop = ~s & d;
			fn_keep_dst:        fdlr_bitop = d;
			fn_xor:             fdlr_bitop = s ^ d;
			fn_or:              fdlr_bitop = s | d;
			fn_nor:             fdlr_bitop = ~(s | d);
			fn_xnor:            fdlr_bitop = ~(s ^ d);
			fn_not_dst:         fdlr_bitop = ~d;
			fn_src_or_not_dst:  fdlr_bitop = s | ~d;
			fn_not_src:         fdlr_bitop = ~s;
			fn_not_src_or_dst:  fdlr_bitop = ~s | d;
			fn_nand:            fdlr_bitop = ~(s & d);
			default:            fdlr_bitop = 8'hff;
		endcase
	endfunction

	// Control fields decoded from the control register, and the window threshold from the fragment position
	logic       dith_en;
	logic       comb_en;
	logic       per_smp;
	logic       smp_buf;
	logic [1:0] tgt;
	logic [1:0] flt;
	logic [3:0] th;
	assign dith_en = st.ctrl[`FDLR_B_DITHER];
	assign comb_en = st.ctrl[`FDLR_B_COMB];
	assign per_smp = st.ctrl[`FDLR_B_PERSMP];
	assign smp_buf = st.ctrl[`FDLR_B_SMPBUF];
	assign tgt     = st.ctrl[`FDLR_F_TGT+1:`FDLR_F_TGT];
	assign flt     = st.ctrl[`FDLR_F_FLT+1:`FDLR_F_FLT];
	assign th      = fdlr_thresh(frag_i.x, frag_i.y);

	// Per buffer datapath: colour after dither, sample results and resolve
	fdlr_color_type [1:0]      dith_c;
	fdlr_color_type [1:0][3:0] res_c;
	logic [1:0][3:0]           smp_wr;
	fdlr_color_type [1:0]      avg_c;

	genvar b, s, k;
	generate
		for (b = 0; b < `FDLR_NBUF; b++) begin : g_buf
			for (k = 0; k < 4; k++) begin : g_cmp
				// Combine enabled selects the unblended colour
				assign dith_c[b][k] = fdlr_reduce(comb_en ? frag_i.src[b][k] : frag_i.blended[b][k],
					dith_en, th);
			end
			for (s = 0; s < `FDLR_NSMP; s++) begin : g_smp
				for (k = 0; k < 4; k++) begin : g_cmp2
					// Combine with this buffer's own stored value; float target ignores it
					assign res_c[b][s][k] = (comb_en && !flt[b]) ?
						fdlr_bitop(st.fn, dith_c[b][k], frag_i.dst[b][s][k]) :
						dith_c[b][k];
				end
				// Sample write permission per mode
				always_comb begin
					if (!tgt[b]) begin
						smp_wr[b][s] = 1'b0;
					end else if (per_smp) begin
						smp_wr[b][s] = frag_i.coverage[s] & frag_i.test_pass[s];
					end else begin
						smp_wr[b][s] = frag_i.test_pass[`FDLR_CTR];
					end
				end
			end
			// Average of the samples after update; kept samples use stored value
			for (k = 0; k < 4; k++) begin : g_avg
				logic [9:0] sum;
				always_comb begin
					sum = 10'h000;
					for (int i = 0; i < `FDLR_NSMP; i++) begin
						sum = sum + {2'b00, (smp_wr[b][i] ? res_c[b][i][k] : frag_i.dst[b][i][k])};
					end
				end
				assign avg_c[b][k] = sum[9:2];
			end
		end
	endgenerate

	// Next state: register port, fragment counter and output stage
	always_comb begin
		next_st = st;
		next_st.rdata = 8'h00;
		next_st.out.valid = 1'b0;
		next_st.out.smp_we = '0;
		next_st.out.buf_we = 2'b00;
		next_st.out.stencil_all = 1'b0;
		// Writes steer the stage from the next fragment on
		if (wr_i) begin
			if (addr_i == `FDLR_CTRL_ADDR) begin
				next_st.ctrl = wdata_i;
			end else if (addr_i == `FDLR_FUNC_ADDR) begin
				next_st.fn = fdlr_fn_type'(wdata_i[3:0]);
			end
		end
		// Unmapped reads return zero
		if (rd_i) begin
			if (addr_i == `FDLR_CTRL_ADDR) begin
				next_st.rdata = st.ctrl;
			end else if (addr_i == `FDLR_FUNC_ADDR) begin
				next_st.rdata = {4'h0, st.fn};
			end else if (addr_i == `FDLR_STAT_ADDR) begin
				next_st.rdata = st.frag_cnt;
			end
		end
		if (frag_i.valid) begin
			next_st.frag_cnt = st.frag_cnt + 8'h01;
			next_st.out.valid = 1'b1;
			next_st.out.smp_color = res_c;
			if (smp_buf) begin
				// Samples first; colour buffers get only the merged value
				next_st.out.smp_we = smp_wr;
				next_st.out.stencil_all = !per_smp && (tgt != 2'b00);
				next_st.out.buf_color = avg_c;
				next_st.out.buf_we = tgt;
			end else begin
				// No sample store: sample 0 carries the stored colour
				next_st.out.buf_color = {res_c[1][0], res_c[0][0]};
				next_st.out.buf_we = tgt;
			end
		end
	end

	// State register; synchronous active-low reset
	// Reset values: dither on, combine off, pass-source function
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st      <= '0;
			st.ctrl <= `FDLR_CTRL_RST;
			st.fn   <= fdlr_fn_type'(`FDLR_FUNC_RST);
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state flops
	assign rdata_o       = st.rdata;
	assign valid_o       = st.out.valid;
	assign smp_we_o      = st.out.smp_we;
	assign smp_color_o   = st.out.smp_color;
	assign stencil_all_o = st.out.stencil_all;
	assign buf_we_o      = st.out.buf_we;
	assign buf_color_o   = st.out.buf_color;
endmodule
`default_nettype wire

// File: logic/fdlr_cfg.svh
// Register offsets, field positions, reset values and widths of the fragment back end
`ifndef FDLR_CFG_SVH
`define FDLR_CFG_SVH
`define FDLR_AW 4
`define FDLR_CTRL_ADDR 4'h0
`define FDLR_FUNC_ADDR 4'h1
`define FDLR_STAT_ADDR 4'h2
`define FDLR_CTRL_RST 8'h11
`define FDLR_FUNC_RST 4'h3
`define FDLR_B_DITHER 0
`define FDLR_B_COMB 1
`define FDLR_B_PERSMP 2
`define FDLR_B_SMPBUF 3
`define FDLR_F_TGT 4
`define FDLR_F_FLT 6
`define FDLR_NBUF 2
`define FDLR_NSMP 4
`define FDLR_FRAC 4
`define FDLR_CTR 0
`endif

// File: logic/fdlr_pkg.sv
// Types shared by the fragment dither and bitwise combine stage
package fdlr_pkg;
	typedef enum logic [3:0] {
		fn_zero, fn_and, fn_src_and_not_dst, fn_copy,
		fn_not_src_and_dst, fn_keep_dst, fn_xor, fn_or,
		fn_nor, fn_xnor, fn_not_dst, fn_src_or_not_dst,
		fn_not_src, fn_not_src_or_dst, fn_nand, fn_set
	} fdlr_fn_type;
	typedef logic [3:0][7:0] fdlr_color_type;
	typedef logic [3:0][11:0] fdlr_wide_type;
	typedef struct packed {
		logic                     valid;
		logic [1:0]               x;
		logic [1:0]               y;
		logic [3:0]               coverage;
		logic [3:0]               test_pass;
		fdlr_wide_type [1:0]      src;
		fdlr_wide_type [1:0]      blended;
		fdlr_color_type [1:0][3:0] dst;
	} fdlr_frag_type;
	typedef struct packed {
		logic                      valid;
		logic [1:0][3:0]           smp_we;
		fdlr_color_type [1:0][3:0] smp_color;
		logic                      stencil_all;
		logic [1:0]                buf_we;
		fdlr_color_type [1:0]      buf_color;
	} fdlr_out_type;
	typedef struct packed {
		logic [7:0]   ctrl;
		fdlr_fn_type  fn;
		logic [7:0]   frag_cnt;
		logic [7:0]   rdata;
		fdlr_out_type out;
	} fdlr_state_type;
endpackage

// File: tb/fdlr_sva.sv
// Port checker for the fragment back end
`timescale 1ns/100ps
`default_nettype none
module fdlr_sva
	import fdlr_pkg::*;
(
	input wire logic                 clk_i,
	input wire logic                 rst_n_i,
	input wire logic [3:0]           addr_i,
	input wire logic [7:0]           wdata_i,
	input wire logic                 wr_i,
	input wire fdlr_frag_type        frag_i,
	input wire logic                 valid_o,
	input wire logic [1:0][3:0]      smp_we_o,
	input wire logic                 stencil_all_o,
	input wire logic [1:0]           buf_we_o,
	input wire fdlr_color_type [1:0] buf_color_o
);
	logic [7:0] c;
	logic [3:0] f;
	wire        v = frag_i.valid;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// Shadow of control and function, rebuilt from writes since the checker cannot see them
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			c <= 8'h11;
			f <= 4'h3;
		end else if (wr_i) begin
			if (addr_i == 4'h0) c <= wdata_i;
			if (addr_i == 4'h1) f <= wdata_i[3:0];
		end
	end
	property p_cov; v && c[3:2] == 2'h3 |=> (smp_we_o & ~{2{$past(frag_i.coverage)}}) == 8'h00; endproperty
	a_cov: assert property (p_cov) else $error("uncovered sample written");
	property p_fail; v && c[3:2] == 2'h3 |=> (smp_we_o & ~{2{$past(frag_i.test_pass)}}) == 8'h00; endproperty
	a_fail: assert property (p_fail) else $error("failed sample written");
	property p_none; v && c[5:4] == 2'h0 |=> smp_we_o == 8'h00 && buf_we_o == 2'h0 && !stencil_all_o; endproperty
	a_none: assert property (p_none) else $error("write with no target");
	property p_tgt; buf_we_o == ({2{$past(v)}} & $past(c[5:4])); endproperty
	a_tgt: assert property (p_tgt) else $error("buffer write mismatch");
	property p_ctr; v && c[3:2] == 2'h2 && c[5:4] != 2'h0 |=> stencil_all_o; endproperty
	a_ctr: assert property (p_ctr) else $error("stencil not spread");
	property p_ctr2; v && c[5:2] == 4'he |=> smp_we_o == {8{$past(frag_i.test_pass[0])}}; endproperty
	a_ctr2: assert property (p_ctr2) else $error("centre result not spread");
	property p_nost; v && !c[3] |=> smp_we_o == 8'h00; endproperty
	a_nost: assert property (p_nost) else $error("sample write without store");
	property p_copy; v && c[6:0] == 7'h12 && f == 4'h3 |=> buf_color_o[0] ==
		$past({frag_i.src[0][3][11:4], frag_i.src[0][2][11:4], frag_i.src[0][1][11:4], frag_i.src[0][0][11:4]});
	endproperty
	a_copy: assert property (p_copy) else $error("blend not bypassed");
endmodule
`default_nettype wire

// File: tb/fdlr_store.sv
// Model of the stored sample colours behind the back end
`timescale 1ns/100ps
`default_nettype none
module fdlr_store
	import fdlr_pkg::*;
(
	input wire logic                      clk_i,
	input wire logic                      rst_n_i,
	input wire logic                      valid_i,
	input wire logic [1:0][3:0]           we_i,
	input wire fdlr_color_type [1:0][3:0] color_i,
	output var fdlr_color_type [1:0][3:0] dst_o
);
	// Distinct reset contents so a wrong sample or buffer index shows up
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < 8; i++) begin
			if (!rst_n_i) dst_o[i/4][i%4] <= 32'(32'h1b2d4f61 * (i + 1));
			else if (valid_i && we_i[i/4][i%4]) dst_o[i/4][i%4] <= color_i[i/4][i%4];
		end
	end
endmodule
`default_nettype wire

// File: tb/test_fdlr_core.sv
// Self-checking bench of the fragment back end
`timescale 1ns/100ps
`default_nettype none
module test_fdlr_core
	import fdlr_pkg::*;
;
	logic                      clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, vo, sta;
	logic [3:0]                addr = 4'h0, fnc = 4'h3;
	logic [7:0]                wdata = 8'h00, ctl = 8'h11, rdata;
	fdlr_frag_type             f = '0;
	fdlr_color_type [1:0][3:0] pd, scol;
	fdlr_color_type [1:0]      bcol;
	logic [1:0][3:0]           swe;
	logic [1:0]                bwe;
	int                        num_errors = 0, check_count = 0, frags = 0;
	wire fdlr_frag_type        fi = {f[$bits(f)-1:256], pd};
	always #2.5 clk = ~clk;
	fdlr_core DUT (.clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .frag_i(fi), .valid_o(vo), .smp_we_o(swe), .smp_color_o(scol),
		.stencil_all_o(sta), .buf_we_o(bwe), .buf_color_o(bcol));
	fdlr_store u_store (.clk_i(clk), .rst_n_i(rst_n), .valid_i(vo), .we_i(swe), .color_i(scol), .dst_o(pd));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Register write; the mirror follows only after the strobe edge
	task automatic wrr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		if (a == 4'h0) ctl = d;
		if (a == 4'h1) fnc = d[3:0];
	endtask
	task automatic rdr(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rdata", e, rdata);
	endtask
	// Dither against the window threshold, then the bitwise function on the stored value
	function automatic fdlr_color_type ex(fdlr_wide_type c, fdlr_color_type d, logic fl);
		logic [7:0] v;
		for (int k = 0; k < 4; k++) begin
			v = c[k][11:4];
			if (ctl[0] && c[k][3:0] > 4'(64'h5d7f91b36e4ca280 >> {f.y, f.x, 2'h0}) && v != 8'hff) v = v + 8'h01;
			if (ctl[1] && !fl) v = {8{fnc[0]}} & v & d[k] | {8{fnc[1]}} & v & ~d[k] |
				{8{fnc[2]}} & ~v & d[k] | {8{fnc[3]}} & ~v & ~d[k];
			ex[k] = v;
		end
	endfunction
	// One fragment; blended differs from source so a missed bypass shows
	task automatic go(input logic [3:0] cov, input logic [3:0] pass, input logic [11:0] base);
		fdlr_color_type [1:0][3:0] d, nc;
		fdlr_color_type [1:0]      bc;
		logic [1:0][3:0]           we;
		logic [9:0]                sum;
		@(posedge clk);
		f.valid <= 1'b1;
		f.coverage <= cov;
		f.test_pass <= pass;
		for (int i = 0; i < 8; i++) begin
			f.src[i/4][i%4] <= base + {5'h00, i[1:0], i[2], 4'h0};
			f.blended[i/4][i%4] <= (base + {5'h00, i[1:0], i[2], 4'h0}) ^ 12'h5a5;
		end
		@(posedge clk);
		f.valid <= 1'b0;
		#1 d = pd;
		frags++;
		for (int b = 0; b < 2; b++) begin
			for (int s = 0; s < 4; s++) begin
				nc[b][s] = ex(ctl[1] ? f.src[b] : f.blended[b], d[b][s], ctl[6 + b]);
				we[b][s] = ctl[4 + b] && ctl[3] && (ctl[2] ? cov[s] & pass[s] : pass[0]);
				if (we[b][s]) chk("smp_color", nc[b][s], scol[b][s]);
				if (we[b][s]) d[b][s] = nc[b][s];
			end
			for (int k = 0; k < 4; k++) begin
				sum = 10'(d[b][0][k]) + d[b][1][k] + d[b][2][k] + d[b][3][k];
				bc[b][k] = ctl[3] ? sum[9:2] : nc[b][0][k];
			end
			if (ctl[4 + b]) chk("buf_color", bc[b], bcol[b]);
		end
		chk("valid", 32'h1, {31'h0, vo});
		chk("buf_we", {30'h0, ctl[5:4]}, {30'h0, bwe});
		chk("smp_we", {24'h0, we}, {24'h0, swe});
		chk("stencil_all", {31'h0, ctl[3] && !ctl[2] && ctl[5:4] != 2'h0}, {31'h0, sta});
	endtask
	initial begin
		#100000 num_errors++;
		report_and_stop();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rdr(4'h0, 8'h11);
		rdr(4'h1, 8'h03);
		rdr(4'hf, 8'h00);
		$display("registers done");
		for (int i = 0; i < 16; i++) begin
			f.x <= i[1:0];
			f.y <= i[3:2];
			go(4'hf, 4'hf, {8'hff, i[3:0]});
			go(4'hf, 4'hf, {8'h47, i[3:0]});
		end
		$display("dither done");
		wrr(4'h0, 8'h10);
		for (int i = 0; i < 4; i++) go(4'hf, 4'hf, {8'h9c, i[1:0], 2'h3});
		wrr(4'h0, 8'h12);
		for (int i = 0; i < 16; i++) begin
			wrr(4'h1, 8'(i));
			go(4'hf, 4'hf, 12'h6c9);
		end
		$display("combine done");
		// Two distinct buffers, never one image twice
		wrr(4'h0, 8'hb3);
		wrr(4'h1, 8'h06);
		go(4'hf, 4'hf, 12'h3a7);
		wrr(4'h0, 8'h33);
		go(4'hf, 4'hf, 12'h3a7);
		wrr(4'h0, 8'h03);
		go(4'hf, 4'hf, 12'h3a7);
		$display("buffers done");
		wrr(4'h0, 8'h3d);
		for (int i = 0; i < 8; i++) go(4'h5 ^ 4'(i), 4'h9 + 4'(i), 12'h815);
		wrr(4'h0, 8'h39);
		go(4'h0, 4'he, 12'h2b8);
		go(4'h0, 4'h1, 12'h2b8);
		rdr(4'h2, 8'(frags));
		$display("samples done");
		report_and_stop();
	end
endmodule
bind fdlr_core fdlr_sva u_sva (.*);
`default_nettype wire
